// file: logic/swl_slave.sv
/*
 * slave end: detects reset, sends presence, times write and read bit slots.
 * assumes line_in synchronous to sys_clk; bits received go out through a fifo,
 * bits to return come in on a plain level input, sampled when a slot's falling edge is seen.
 */
`timescale 1ns/1ps
`default_nettype none
module swl_slave
	import swl_pkg::*;
(
	// clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst_b,
	// line
	swl_line_if.slave                  line,
	// received bits
	output var  logic                  rx_valid,
	input  wire logic                  rx_ready,
	output var  logic [FIFO_WIDTH-1:0] rx_data,
	// bit returned in read slots, 1 = release
	input  wire logic                  tx_bit,
	// status
	output logic                       reset_seen,
	output logic                       ready_for_cmd
);
	import swl_pkg::*;

	typedef enum logic [2:0]
	{
		SL_IDLE   = 3'b000,
		SL_LOW    = 3'b001,
		SL_PWAIT  = 3'b010,
		SL_PLOW   = 3'b011,
		SL_RECOV  = 3'b100
	} swl_sstate_type;

	swl_sstate_type   state_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic             line_d_ff;
	logic             bit_ff;
	logic             ret_ff;
	logic             oe_ff;
	logic             push;
	logic             fall;
	logic             samp_bit;

	assign fall = line_d_ff & ~line.line_in;

	swl_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.in_valid  (push),
		.in_ready  (),
		.in_data   ({{(FIFO_WIDTH-1){1'b0}}, samp_bit}),
		.out_valid (rx_valid),
		.out_ready (rx_ready),
		.out_data  (rx_data)
	);

	// push when the line rises to end a slot's low time; a full fifo drops the bit, reader must keep up
	assign push = (state_ff == SL_LOW) && line.line_in && (cnt_ff < CNT_W'(RESET_DETECT_CYC));

	// push and the sample register share an edge, so the pushed bit is formed here:
	// a slot whose line rises by the sample point carries a one
	assign samp_bit = (cnt_ff <= CNT_W'(WRITE_SAMPLE_CYC)) ? 1'b1 : bit_ff;

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			line_d_ff <= 1'b1;
		else
			line_d_ff <= line.line_in;
	end

	// ==========================================
	// slot timer and state
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_ff      <= SL_IDLE;
			cnt_ff        <= '0;
			bit_ff        <= 1'b0;
			ret_ff        <= 1'b1;
			reset_seen    <= 1'b0;
			ready_for_cmd <= 1'b0;
		end
		else
		begin
			case (state_ff)
				SL_IDLE:
				begin
					if (fall)
					begin
						state_ff <= SL_LOW;
						cnt_ff   <= '0;
						ret_ff   <= tx_bit;
					end
				end
				SL_LOW:
				begin
					if (cnt_ff != '1)
						cnt_ff <= cnt_ff + 1'b1;
					if (cnt_ff == CNT_W'(WRITE_SAMPLE_CYC))
						bit_ff <= line.line_in;
					if (line.line_in)
					begin
						if (cnt_ff >= CNT_W'(RESET_DETECT_CYC))
						begin
							state_ff   <= SL_PWAIT;
							reset_seen <= 1'b1;
						end
						else
						begin
							if (cnt_ff < CNT_W'(WRITE_SAMPLE_CYC))
								bit_ff <= 1'b1;
							state_ff <= SL_RECOV;
						end
						cnt_ff <= '0;
					end
				end
				SL_PWAIT:
				begin
					cnt_ff <= cnt_ff + 1'b1;
					if (cnt_ff == CNT_W'(PRESENCE_WAIT_CYC - 1))
					begin
						state_ff <= SL_PLOW;
						cnt_ff   <= '0;
					end
				end
				SL_PLOW:
				begin
					cnt_ff <= cnt_ff + 1'b1;
					if (cnt_ff == CNT_W'(PRESENCE_LOW_CYC - 1))
					begin
						state_ff      <= SL_RECOV;
						cnt_ff        <= '0;
						ready_for_cmd <= 1'b1;
					end
				end
				SL_RECOV:
				begin
					if (!line.line_in)
						cnt_ff <= '0;
					else if (cnt_ff == CNT_W'(SLOT_RECOVERY_CYC - 1))
					begin
						state_ff <= SL_IDLE;
						cnt_ff   <= '0;
					end
					else
						cnt_ff <= cnt_ff + 1'b1;
				end
				default: state_ff <= SL_IDLE;
			endcase
		end
	end

	// ==========================================
	// line drive: presence, or a returned zero until the timer ends
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			oe_ff <= 1'b0;
		else
			oe_ff <= (state_ff == SL_PLOW)
				|| (state_ff == SL_IDLE && fall && !tx_bit)
				|| (state_ff == SL_LOW && !ret_ff && cnt_ff < CNT_W'(SLAVE_PULLDOWN_CYC - 1));
	end

	assign line.s_oe = oe_ff;
endmodule : swl_slave
`default_nettype wire

// file: shared/swl_pkg.sv
/*
 * constants and types shared by both ends of the single-wire signalling link.
 * assumes a 100 MHz system clock on both ends and an open-drain line resolved outside.
 */
package swl_pkg;

	// ==========================================
	// timing, in ns, and derived cycle counts; plain defaults, tune per bus
	localparam int CLK_PERIOD_NS          = 10;
	localparam int RESET_LOW_TIME_NS      = 150000;  // must outlast the slave's reset detect time
	localparam int RESET_DETECT_TIME_NS   = 120000;
	localparam int FALL_TIME_NS           = 0;
	localparam int PRESENCE_WAIT_TIME_NS  = 30000;
	localparam int PRESENCE_LOW_TIME_NS   = 120000;
	localparam int PRESENCE_SAMPLE_TIME_NS = 70000;
	localparam int RESET_HIGH_TIME_NS     = 200000;  // must cover presence wait, presence low and recovery
	localparam int WRITE_ONE_LOW_TIME_NS  = 6000;
	localparam int WRITE_ZERO_LOW_TIME_NS = 60000;
	localparam int READ_LOW_TIME_NS       = 6000;
	localparam int READ_SAMPLE_TIME_NS    = 13000;
	localparam int WRITE_SAMPLE_TIME_NS   = 30000;
	localparam int SLAVE_PULLDOWN_TIME_NS = 30000;
	localparam int SLOT_RECOVERY_TIME_NS  = 5000;
	localparam int SLOT_DURATION_NS       = 70000;

	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : ns_to_cyc

	localparam int RESET_LOW_CYC       = ns_to_cyc(RESET_LOW_TIME_NS + FALL_TIME_NS);
	localparam int RESET_DETECT_CYC    = ns_to_cyc(RESET_DETECT_TIME_NS);
	localparam int PRESENCE_WAIT_CYC   = ns_to_cyc(PRESENCE_WAIT_TIME_NS);
	localparam int PRESENCE_LOW_CYC    = ns_to_cyc(PRESENCE_LOW_TIME_NS);
	localparam int PRESENCE_SAMPLE_CYC = ns_to_cyc(PRESENCE_SAMPLE_TIME_NS);
	localparam int RESET_HIGH_CYC      = ns_to_cyc(RESET_HIGH_TIME_NS);
	localparam int WRITE_ONE_LOW_CYC   = ns_to_cyc(WRITE_ONE_LOW_TIME_NS);
	localparam int WRITE_ZERO_LOW_CYC  = ns_to_cyc(WRITE_ZERO_LOW_TIME_NS);
	localparam int READ_LOW_CYC        = ns_to_cyc(READ_LOW_TIME_NS);
	localparam int READ_SAMPLE_CYC     = READ_SAMPLE_TIME_NS / CLK_PERIOD_NS;
	localparam int WRITE_SAMPLE_CYC    = ns_to_cyc(WRITE_SAMPLE_TIME_NS);
	localparam int SLAVE_PULLDOWN_CYC  = SLAVE_PULLDOWN_TIME_NS / CLK_PERIOD_NS;
	localparam int SLOT_RECOVERY_CYC   = ns_to_cyc(SLOT_RECOVERY_TIME_NS);
	localparam int SLOT_DURATION_CYC   = ns_to_cyc(SLOT_DURATION_NS);

	localparam int CNT_W       = 20;
	localparam int FIFO_WIDTH  = 8;
	localparam int FIFO_DEPTH  = 16;

	// ==========================================
	// master operation codes
	typedef enum logic [1:0]
	{
		SWL_OP_RESET = 2'b00,
		SWL_OP_WRITE = 2'b01,
		SWL_OP_READ  = 2'b10
	} swl_op_type;

endpackage : swl_pkg

// file: shared/swl_line_if.sv
/*
 * the shared open-drain line between master and slave.
 * assumes an external pull-up: the line is high unless some end drives low.
 */
`timescale 1ns/1ps
`default_nettype none
interface swl_line_if;
	logic m_oe;
	logic s_oe;
	logic line_in;

	// wired-and of open-drain drivers
	assign line_in = ~(m_oe | s_oe);

	modport master (output m_oe, input line_in);
	modport slave  (output s_oe, input line_in);
endinterface : swl_line_if
`default_nettype wire

// file: logic/swl_fifo.sv
/*
 * synchronous valid/ready fifo, width and depth as parameters.
 * assumes one clock and depth a power of two.
 */
`timescale 1ns/1ps
`default_nettype none
module swl_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
)(
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst_b,
	// fill side
	input  wire logic             in_valid,
	output var  logic             in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output var  logic             out_valid,
	input  wire logic             out_ready,
	output var  logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr_ff;
	logic [AW:0]      rd_ptr_ff;
	logic             do_wr;
	logic             do_rd;

	assign in_ready  = (wr_ptr_ff - rd_ptr_ff) != (AW+1)'(DEPTH);
	assign out_valid = wr_ptr_ff != rd_ptr_ff;
	assign do_wr     = in_valid & in_ready;
	assign do_rd     = out_valid & out_ready;
	assign out_data  = mem[rd_ptr_ff[AW-1:0]];

	always_ff @(posedge sys_clk)
	begin
		if (do_wr)
			mem[wr_ptr_ff[AW-1:0]] <= in_data;
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
		end
		else
		begin
			if (do_wr)
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			if (do_rd)
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
		end
	end
endmodule : swl_fifo
`default_nettype wire

// file: logic/swl_master.sv
/*
 * master end: starts reset, write and read slots on request.
 * assumes line_in synchronous to sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module swl_master
	import swl_pkg::*;
(
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	// line
	swl_line_if.master      line,
	// request
	input  wire logic       req_valid,
	output logic            req_ready,
	input  wire swl_op_type req_op,
	input  wire logic       req_bit,
	// answer
	output logic            done,
	output logic            done_bit
);
	import swl_pkg::*;

	typedef enum logic [1:0]
	{
		MS_IDLE = 2'b00,
		MS_SLOT = 2'b01
	} swl_mstate_type;

	swl_mstate_type   state_ff;
	swl_op_type       op_ff;
	logic             bit_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] low_len;
	logic [CNT_W-1:0] end_len;
	logic [CNT_W-1:0] samp_at;
	logic             oe_ff;

	assign req_ready = (state_ff == MS_IDLE);

	always_comb
	begin
		case (op_ff)
			SWL_OP_RESET:
			begin
				low_len = CNT_W'(RESET_LOW_CYC);
				samp_at = CNT_W'(RESET_LOW_CYC + PRESENCE_SAMPLE_CYC);
				end_len = CNT_W'(RESET_LOW_CYC + RESET_HIGH_CYC);
			end
			SWL_OP_READ:
			begin
				low_len = CNT_W'(READ_LOW_CYC);
				samp_at = CNT_W'(READ_SAMPLE_CYC);
				end_len = CNT_W'(SLOT_DURATION_CYC + SLOT_RECOVERY_CYC);
			end
			default:
			begin
				low_len = bit_ff ? CNT_W'(WRITE_ONE_LOW_CYC) : CNT_W'(WRITE_ZERO_LOW_CYC);
				samp_at = '1;
				end_len = CNT_W'(SLOT_DURATION_CYC + SLOT_RECOVERY_CYC);
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_ff <= MS_IDLE;
			op_ff    <= SWL_OP_RESET;
			bit_ff   <= 1'b0;
			cnt_ff   <= '0;
			oe_ff    <= 1'b0;
			done     <= 1'b0;
			done_bit <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			case (state_ff)
				MS_IDLE:
				begin
					if (req_valid)
					begin
						state_ff <= MS_SLOT;
						op_ff    <= req_op;
						bit_ff   <= req_bit;
						cnt_ff   <= '0;
						oe_ff    <= 1'b1;
					end
				end
				MS_SLOT:
				begin
					cnt_ff <= cnt_ff + 1'b1;
					if (cnt_ff == low_len - 1'b1)
						oe_ff <= 1'b0;
					if (cnt_ff == samp_at)
						done_bit <= (op_ff == SWL_OP_RESET) ? ~line.line_in : line.line_in;
					if (cnt_ff == end_len - 1'b1)
					begin
						state_ff <= MS_IDLE;
						done     <= 1'b1;
					end
				end
				default: state_ff <= MS_IDLE;
			endcase
		end
	end

	assign line.m_oe = oe_ff;
endmodule : swl_master
`default_nettype wire

// file: bench/swl_link_sva.sv
/*
 * checker for the shared line between the master and slave ends.
 * assumes the interface signals as plain inputs and one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module swl_link_sva
	import swl_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// line
	input wire logic m_oe,
	input wire logic s_oe,
	input wire logic line_in
);
	localparam int WAIT_LO = PRESENCE_WAIT_CYC - 2;
	localparam int WAIT_HI = PRESENCE_WAIT_CYC + 2;
	int   m_len_ff;
	int   s_len_ff;
	int   hi_len_ff;
	int   rise_gap_ff;
	int   lo_m_ff;
	logic act_ff;
	logic rst_ff;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	// ==========================================
	// run lengths, slack of two on synchroniser delay
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			m_len_ff <= 0;
			s_len_ff <= 0;
			hi_len_ff <= 0;
			rise_gap_ff <= 0;
			lo_m_ff <= 0;
		end
		else
		begin
			m_len_ff <= m_oe ? m_len_ff + 1 : 0;
			s_len_ff <= s_oe ? s_len_ff + 1 : 0;
			hi_len_ff <= line_in ? hi_len_ff + 1 : 0;
			rise_gap_ff <= (m_oe && m_len_ff == 0) ? 1 : rise_gap_ff + 1;
			lo_m_ff <= m_oe ? 0 : lo_m_ff + 1;
		end
	end

	// ==========================================
	// what the master started last
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			act_ff <= 1'b0;
			rst_ff <= 1'b0;
		end
		else
		begin
			act_ff <= act_ff | m_oe;
			if (!m_oe && m_len_ff != 0)
				rst_ff <= (m_len_ff >= RESET_LOW_CYC);
		end
	end

	// ==========================================
	// line rules
	a_master_low_len: assert property ($fell(m_oe) |-> m_len_ff inside
		{RESET_LOW_CYC, WRITE_ZERO_LOW_CYC, WRITE_ONE_LOW_CYC, READ_LOW_CYC})
		else $error("master low time off");
	a_master_low_cap: assert property (m_len_ff <= RESET_LOW_CYC)
		else $error("master holds line low too long");
	a_slave_low_len: assert property ($fell(s_oe) |-> s_len_ff inside
		{PRESENCE_LOW_CYC, SLAVE_PULLDOWN_CYC})
		else $error("slave low time off");
	a_slave_low_cap: assert property (s_len_ff <= PRESENCE_LOW_CYC)
		else $error("slave holds line low too long");
	a_presence_wait: assert property ($rose(s_oe) && !$past(m_oe) |->
		hi_len_ff inside {[WAIT_LO:WAIT_HI]})
		else $error("presence wait off");
	a_read_pull_in: assert property ($rose(s_oe) && $past(m_oe) |-> m_oe)
		else $error("read pulldown outside read low");
	a_slot_recovery: assert property ($rose(m_oe) && act_ff |-> hi_len_ff >= SLOT_RECOVERY_CYC)
		else $error("slot started within recovery");
	a_slot_period: assert property ($rose(m_oe) && act_ff && !rst_ff |-> rise_gap_ff >= SLOT_DURATION_CYC)
		else $error("slot shorter than slot duration");
	a_reset_high_gap: assert property ($rose(m_oe) && rst_ff |-> lo_m_ff >= RESET_HIGH_CYC)
		else $error("traffic within reset high time");
endmodule : swl_link_sva
`default_nettype wire

// file: bench/single_wire_slave_signaling_test.sv
/*
 * testbench joining master and slave over one line interface.
 * assumes package timing constants; a reset op is the longest wait.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_errors++; \
	$display("mismatch %s expected %h seen %h", nm, ex, got); end end
module single_wire_slave_signaling_test;
	import swl_pkg::*;
	logic                  sys_clk;
	logic                  rst_b;
	logic                  req_valid;
	logic                  req_bit;
	logic                  tx_bit;
	logic                  rx_ready;
	swl_op_type            req_op;
	logic                  req_ready;
	logic                  done;
	logic                  done_bit;
	logic                  rx_valid;
	logic                  reset_seen;
	logic                  ready_for_cmd;
	logic [FIFO_WIDTH-1:0] rx_data;
	int                    n_errors;
	int                    n_compared;

	swl_line_if line_if ();
	swl_master i_swl_master (.sys_clk(sys_clk), .rst_b(rst_b), .line(line_if.master), .req_valid(req_valid),
		.req_ready(req_ready), .req_op(req_op), .req_bit(req_bit), .done(done), .done_bit(done_bit));
	swl_slave i_swl_slave (.sys_clk(sys_clk), .rst_b(rst_b), .line(line_if.slave), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .rx_data(rx_data), .tx_bit(tx_bit), .reset_seen(reset_seen),
		.ready_for_cmd(ready_for_cmd));
	swl_link_sva i_swl_link_sva (.sys_clk(sys_clk), .rst_b(rst_b), .m_oe(line_if.m_oe),
		.s_oe(line_if.s_oe), .line_in(line_if.line_in));

	// ==========================================
	// tasks
	task automatic test_done;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done

	task automatic run_op(input swl_op_type op, input logic b, input logic exp_bit);
		int i;
		i = 0;
		req_op <= op;
		req_bit <= b;
		req_valid <= 1'b1;
		do @(posedge sys_clk); while (req_ready !== 1'b1 && ++i < 16);
		`CHK("req_ready", 1'b1, req_ready)
		req_valid <= 1'b0;
		// a reset takes the longest, low plus high time
		for (i = 0; i < RESET_LOW_CYC + RESET_HIGH_CYC + 16 && done !== 1'b1; i++)
			@(posedge sys_clk);
		if (i >= RESET_LOW_CYC + RESET_HIGH_CYC + 16)
		begin
			n_errors++;
			$display("mismatch done expected 1 seen 0");
			test_done();
		end
		if (op != SWL_OP_WRITE)
			`CHK("done_bit", exp_bit, done_bit)
	endtask : run_op

	task automatic drain(input logic exp_bit);
		int i;
		for (i = 0; i < 64 && rx_valid !== 1'b1; i++)
			@(posedge sys_clk);
		`CHK("rx_valid", 1'b1, rx_valid)
		`CHK("rx_bit", exp_bit, rx_data[0])
		rx_ready <= 1'b1;
		@(posedge sys_clk);
		rx_ready <= 1'b0;
		// let the pop land before the fifo is looked at again
		@(posedge sys_clk);
	endtask : drain

	// ==========================================
	// clock and sequence
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	initial
	begin
		int k;
		rst_b = 1'b0;
		req_valid = 1'b0;
		req_bit = 1'b0;
		req_op = SWL_OP_RESET;
		tx_bit = 1'b1;
		rx_ready = 1'b0;
		n_errors = 0;
		n_compared = 0;
		repeat (12) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		`CHK("ready_for_cmd", 1'b0, ready_for_cmd)
		run_op(SWL_OP_RESET, 1'b0, 1'b1);
		`CHK("reset_seen", 1'b1, reset_seen)
		`CHK("ready_for_cmd", 1'b1, ready_for_cmd)
		// write zero, write one, read zero, read one; reads also land in the fifo
		for (k = 0; k < 4; k++)
		begin
			tx_bit <= k[0];
			run_op((k < 2) ? SWL_OP_WRITE : SWL_OP_READ, k[0], k[0]);
			// a read zero lands as zero only if its pulldown outlasts the write sample point
			drain(k[0] | (k > 1 && SLAVE_PULLDOWN_CYC <= WRITE_SAMPLE_CYC));
		end
		// back to back slots keep line order
		run_op(SWL_OP_WRITE, 1'b0, 1'b0);
		run_op(SWL_OP_WRITE, 1'b1, 1'b1);
		drain(1'b0);
		drain(1'b1);
		test_done();
	end
endmodule : single_wire_slave_signaling_test
`default_nettype wire
